// [fll_clock_mode_control_consts.svh]
// register map, field positions, reset values and counts for the clock mode controller
`ifndef FLL_CLOCK_MODE_CONTROL_CONSTS_SVH
`define FLL_CLOCK_MODE_CONTROL_CONSTS_SVH

`define OFF_CTRL1 8'h00
`define OFF_CTRL2 8'h04
`define OFF_REF_TRIM 8'h08
`define OFF_CLOCK_STATUS_FINE_TRIM 8'h0C

`define CTRL1_CLKSEL_HI 7
`define CTRL1_CLKSEL_LO 6
`define CTRL1_REFDIV_HI 5
`define CTRL1_REFDIV_LO 3
`define CTRL1_IREF_SEL 2
`define CTRL1_IREF_OE 1
`define CTRL1_IREF_STOP 0

`define CTRL2_BUSDIV_HI 7
`define CTRL2_BUSDIV_LO 6
`define CTRL2_RANGE 5
`define CTRL2_GAIN 4
`define CTRL2_LOWPOWER 3
`define CTRL2_OSC_REQ 2
`define CTRL2_EREF_OE 1
`define CTRL2_EREF_STOP 0

`define STAT_MODE_HI 3
`define STAT_MODE_LO 2
`define STAT_OSC_DONE 1
`define STAT_FINE_TRIM 0

`define CTRL1_RESET 8'h04
`define CTRL2_RESET 8'h40
`define REF_TRIM_RESET 8'h80
`define FINE_TRIM_RESET 1'h0

`define SRC_FLL 2'h0
`define SRC_INTERNAL 2'h1
`define SRC_EXTERNAL 2'h2
`define SRC_RESERVED 2'h3

`define FLL_MULTIPLIER 10'h200
`define SWITCH_EDGES 4
`define RELOCK_EDGES 4

`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// [fll_clock_mode_control_pkg.sv]
// types shared by the clock mode controller
package fll_clock_mode_control_pkg;
    typedef enum logic [1:0] {sw_idle, sw_count} switch_state_t;
    typedef enum logic [2:0] {
        fll_engaged_internal_mode,
        fll_engaged_external_mode,
        bypass_internal_mode,
        bypass_internal_low_power_mode,
        bypass_external_mode,
        bypass_external_low_power_mode
    } op_mode_t;
endpackage

// [fll_clock_mode_control.sv]
// clock mode controller with axi4-lite register slave
// Functional notes
// - trim bits weight the reference period binarily
// - larger trim value gives longer reference period
// - fine trim bit adds smallest period step
// - mode state reports fll, internal, external source
// - mode state follows select after synchronised switch
// - osc done sets after oscillator startup completes
// - osc done clears only when enable/request clear
// - reset leaves fll engaged internal mode
// - fll locks at 512 times divided reference
// - select 00 external ref gives fll engaged external
// - internal bypass keeps fll locked when allowed
// - internal low power bypass disables fll, debug
// - external bypass keeps fll locked when allowed
// - external low power bypass disables fll, debug
// - stop halts clocks; internal ref kept if enabled
// - external ref runs in stop when enabled
// - fll relocks after few divided reference cycles
// - source switch waits several new clock cycles
// - missing new source keeps previous source selected
// - bus divider acts immediately
// - bus divider 1,2,4,8; reset divide by 2
// - reference divider is two to the code
// - reserved select code behaves as fll output
`timescale 1ns/1ns
`include "fll_clock_mode_control_consts.svh"

module fll_clock_mode_control
    import fll_clock_mode_control_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int SWITCH_EDGES = `SWITCH_EDGES,
    parameter int RELOCK_EDGES = `RELOCK_EDGES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic int_ref_clk,
    input wire logic ext_ref_clk,
    input wire logic fll_clk,
    input wire logic ext_osc_ready,
    input wire logic stop_mode,
    input wire logic debug_mode_active,
    output logic core_clock_out,
    output logic debug_link_clock,
    output logic int_ref_clock_out,
    output logic ext_ref_clock_out,
    output logic fll_enable,
    output logic fll_ref_clk,
    output logic fll_relock_start,
    output logic [9:0] fll_multiplier,
    output logic [8:0] int_ref_period_code,
    output logic ext_osc_enable,
    output logic ext_osc_high_range,
    output logic ext_osc_high_gain
);
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] ref_trim;
    logic fine_period_trim;
    logic osc_startup_done;
    logic [1:0] clock_mode_state;

    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic do_write;
    logic wr_hit;
    logic [31:0] next_rdata;
    logic rd_hit;

    logic [1:0] clock_source_select;
    logic [2:0] reference_divider;
    logic reference_internal_select;
    logic int_ref_output_enable;
    logic int_ref_stop_keep;
    logic [1:0] bus_divider;
    logic bypass_fll_power_down;
    logic ext_osc_request;
    logic ext_ref_output_enable;
    logic ext_ref_stop_keep;

    op_mode_t op_mode;
    logic [1:0] req_src;
    logic fll_on;
    logic ext_ref_used;

    logic int_prev, ext_prev, fll_prev, sel_prev;
    logic [6:0] ref_cnt;
    logic [7:0] ref_taps;
    logic ref_src;
    logic [2:0] bus_cnt;
    logic [3:0] bus_taps;
    logic sel_clk;
    logic new_edge;
    logic new_src_clk;
    logic new_src_prev;

    switch_state_t sw_state;
    logic [7:0] sw_cnt;
    logic [1:0] sw_target;
    logic iref_prev;
    logic relock_pending;
    logic [7:0] relock_cnt;

    assign clock_source_select = ctrl1[`CTRL1_CLKSEL_HI:`CTRL1_CLKSEL_LO];
    assign reference_divider = ctrl1[`CTRL1_REFDIV_HI:`CTRL1_REFDIV_LO];
    assign reference_internal_select = ctrl1[`CTRL1_IREF_SEL];
    assign int_ref_output_enable = ctrl1[`CTRL1_IREF_OE];
    assign int_ref_stop_keep = ctrl1[`CTRL1_IREF_STOP];
    assign bus_divider = ctrl2[`CTRL2_BUSDIV_HI:`CTRL2_BUSDIV_LO];
    assign bypass_fll_power_down = ctrl2[`CTRL2_LOWPOWER];
    assign ext_osc_request = ctrl2[`CTRL2_OSC_REQ];
    assign ext_ref_output_enable = ctrl2[`CTRL2_EREF_OE];
    assign ext_ref_stop_keep = ctrl2[`CTRL2_EREF_STOP];

    // write channel: address and data taken in either order
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_hit = (wr_addr == `OFF_CTRL1) || (wr_addr == `OFF_CTRL2) ||
                    (wr_addr == `OFF_REF_TRIM) || (wr_addr == `OFF_CLOCK_STATUS_FINE_TRIM);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            wr_addr <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_wready <= 1'b1;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register writes; only byte lane 0 carries data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl1 <= `CTRL1_RESET;
        end else if (ce && do_write && wr_strb[0] && wr_addr == `OFF_CTRL1) begin
            ctrl1 <= wr_data[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl2 <= `CTRL2_RESET;
        end else if (ce && do_write && wr_strb[0] && wr_addr == `OFF_CTRL2) begin
            ctrl2 <= wr_data[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_trim <= `REF_TRIM_RESET;
            fine_period_trim <= `FINE_TRIM_RESET;
        end else if (ce && do_write && wr_strb[0]) begin
            if (wr_addr == `OFF_REF_TRIM) begin
                ref_trim <= wr_data[7:0];
            end
            if (wr_addr == `OFF_CLOCK_STATUS_FINE_TRIM) begin
                fine_period_trim <= wr_data[`STAT_FINE_TRIM];
            end
        end
    end

    // read channel
    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `OFF_CTRL1: next_rdata[7:0] = ctrl1;
            `OFF_CTRL2: next_rdata[7:0] = ctrl2;
            `OFF_REF_TRIM: next_rdata[7:0] = ref_trim;
            `OFF_CLOCK_STATUS_FINE_TRIM: next_rdata[3:0] =
                {clock_mode_state, osc_startup_done, fine_period_trim};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // mode decode from current register values and debug state
    always_comb begin
        req_src = (clock_source_select == `SRC_RESERVED) ? `SRC_FLL : clock_source_select;
        unique case (req_src)
            `SRC_INTERNAL: op_mode = (debug_mode_active || !bypass_fll_power_down) ?
                bypass_internal_mode : bypass_internal_low_power_mode;
            `SRC_EXTERNAL: op_mode = (debug_mode_active || !bypass_fll_power_down) ?
                bypass_external_mode : bypass_external_low_power_mode;
            default: op_mode = reference_internal_select ?
                fll_engaged_internal_mode : fll_engaged_external_mode;
        endcase
        fll_on = (op_mode != bypass_internal_low_power_mode) &&
                 (op_mode != bypass_external_low_power_mode);
        ext_ref_used = ext_ref_output_enable || op_mode == fll_engaged_external_mode ||
                       op_mode == bypass_external_mode ||
                       op_mode == bypass_external_low_power_mode;
    end

    // divided reference: tap k is the reference divided by 2^k
    assign ref_src = reference_internal_select ? int_ref_clk : ext_ref_clk;
    assign ref_taps = {ref_cnt, ref_src};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_cnt <= '0;
            fll_ref_clk <= 1'b0;
            int_prev <= 1'b0;
            ext_prev <= 1'b0;
            fll_prev <= 1'b0;
        end else if (ce) begin
            int_prev <= int_ref_clk;
            ext_prev <= ext_ref_clk;
            fll_prev <= fll_clk;
            if (ref_src && !(reference_internal_select ? int_prev : ext_prev)) begin
                ref_cnt <= ref_cnt + 7'h01;
            end
            fll_ref_clk <= !stop_mode && ref_taps[reference_divider];
        end
    end

    // relock after reference select change, counted in new divided reference cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            iref_prev <= 1'b1;
            relock_pending <= 1'b0;
            relock_cnt <= 8'h00;
            fll_relock_start <= 1'b0;
        end else if (ce) begin
            iref_prev <= reference_internal_select;
            fll_relock_start <= 1'b0;
            if (reference_internal_select != iref_prev) begin
                relock_pending <= 1'b1;
                relock_cnt <= 8'h00;
            // new tap against last output: the select change itself is no edge
            end else if (relock_pending && !stop_mode && !fll_ref_clk &&
                         ref_taps[reference_divider]) begin
                if (relock_cnt == 8'(RELOCK_EDGES - 1)) begin
                    relock_pending <= 1'b0;
                    fll_relock_start <= 1'b1;
                end else begin
                    relock_cnt <= relock_cnt + 8'h01;
                end
            end
        end
    end

    // source switch: needs edges of the new clock before it takes over
    always_comb begin
        unique case (sw_target)
            `SRC_INTERNAL: begin
                new_src_clk = int_ref_clk;
                new_src_prev = int_prev;
            end
            `SRC_EXTERNAL: begin
                new_src_clk = ext_ref_clk;
                new_src_prev = ext_prev;
            end
            default: begin
                new_src_clk = fll_clk;
                new_src_prev = fll_prev;
            end
        endcase
        new_edge = new_src_clk && !new_src_prev;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_state <= sw_idle;
            sw_cnt <= 8'h00;
            sw_target <= `SRC_FLL;
            clock_mode_state <= `SRC_FLL;
        end else if (ce) begin
            unique case (sw_state)
                sw_idle: begin
                    if (req_src != clock_mode_state) begin
                        sw_state <= sw_count;
                        sw_target <= req_src;
                        sw_cnt <= 8'h00;
                    end
                end
                sw_count: begin
                    if (req_src != sw_target) begin
                        sw_state <= sw_idle;
                    end else if (new_edge) begin
                        if (sw_cnt == 8'(SWITCH_EDGES - 1)) begin
                            clock_mode_state <= sw_target;
                            sw_state <= sw_idle;
                        end else begin
                            sw_cnt <= sw_cnt + 8'h01;
                        end
                    end
                end
            endcase
        end
    end

    // bus divider on the active source, takes effect at once
    always_comb begin
        unique case (clock_mode_state)
            `SRC_INTERNAL: sel_clk = int_ref_clk;
            `SRC_EXTERNAL: sel_clk = ext_ref_clk;
            default: sel_clk = fll_clk;
        endcase
    end
    assign bus_taps = {bus_cnt, sel_clk};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_prev <= 1'b0;
            bus_cnt <= 3'h0;
            core_clock_out <= 1'b0;
        end else if (ce) begin
            sel_prev <= sel_clk;
            if (sel_clk && !sel_prev) begin
                bus_cnt <= bus_cnt + 3'h1;
            end
            core_clock_out <= !stop_mode && bus_taps[bus_divider];
        end
    end

    // oscillator startup status; set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_startup_done <= 1'b0;
        end else if (ce) begin
            if (ext_osc_request && ext_ref_used && ext_osc_ready) begin
                osc_startup_done <= 1'b1;
            end else if (!ext_osc_request || !ext_ref_used) begin
                osc_startup_done <= 1'b0;
            end
        end
    end

    // clock outputs, fll control and trim drive
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            debug_link_clock <= 1'b0;
            int_ref_clock_out <= 1'b0;
            ext_ref_clock_out <= 1'b0;
            fll_enable <= 1'b0;
            fll_multiplier <= `FLL_MULTIPLIER;
            int_ref_period_code <= {`REF_TRIM_RESET, `FINE_TRIM_RESET};
            ext_osc_enable <= 1'b0;
            ext_osc_high_range <= 1'b0;
            ext_osc_high_gain <= 1'b0;
        end else if (ce) begin
            fll_enable <= fll_on && !stop_mode;
            fll_multiplier <= `FLL_MULTIPLIER;
            debug_link_clock <= fll_on && !stop_mode && fll_clk;
            int_ref_clock_out <= int_ref_output_enable && (!stop_mode || int_ref_stop_keep) &&
                                 int_ref_clk;
            ext_ref_clock_out <= ext_ref_output_enable && (!stop_mode || ext_ref_stop_keep) &&
                                 ext_ref_clk;
            // larger code, longer period; fine bit is the least weight
            int_ref_period_code <= {ref_trim, fine_period_trim};
            ext_osc_enable <= ext_osc_request && ext_ref_used &&
                              (!stop_mode || ext_ref_stop_keep);
            ext_osc_high_range <= ctrl2[`CTRL2_RANGE];
            ext_osc_high_gain <= ctrl2[`CTRL2_GAIN];
        end
    end
endmodule

// [fll_clock_mode_control_assertions.sv]
// port-level concurrent checks for the clock mode controller
`timescale 1ns/1ns

module fll_clock_mode_control_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic int_ref_clk,
    input wire logic ext_ref_clk,
    input wire logic stop_mode,
    input wire logic core_clock_out,
    input wire logic debug_link_clock,
    input wire logic int_ref_clock_out,
    input wire logic ext_ref_clock_out,
    input wire logic fll_enable,
    input wire logic fll_ref_clk,
    input wire logic fll_relock_start,
    input wire logic [9:0] fll_multiplier
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_in_stop; $past(stop_mode) && $past(ce); endsequence

    property p_mult; fll_multiplier == 10'h200; endproperty
    a_mult: assert property (p_mult) else $error("fll multiplier wrong");
    property p_stop_core; s_in_stop |-> !core_clock_out; endproperty
    a_stop_core: assert property (p_stop_core) else $error("core clock in stop");
    property p_stop_dbg; s_in_stop |-> !debug_link_clock; endproperty
    a_stop_dbg: assert property (p_stop_dbg) else $error("debug clock in stop");
    property p_stop_fll; s_in_stop |-> !fll_enable; endproperty
    a_stop_fll: assert property (p_stop_fll) else $error("fll on in stop");
    property p_stop_ref; s_in_stop |-> !fll_ref_clk; endproperty
    a_stop_ref: assert property (p_stop_ref) else $error("reference out in stop");
    property p_irc; int_ref_clock_out |-> $past(int_ref_clk) || $past(int_ref_clk, 2); endproperty
    a_irc: assert property (p_irc) else $error("internal ref out not a copy");
    property p_erc; ext_ref_clock_out |-> $past(ext_ref_clk) || $past(ext_ref_clk, 2); endproperty
    a_erc: assert property (p_erc) else $error("external ref out not a copy");
    property p_relock; fll_relock_start && ce |=> !fll_relock_start; endproperty
    a_relock: assert property (p_relock) else $error("relock pulse too long");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read response dropped");
    property p_wresp; s_wr_both |-> ##[1:2] s_axi_bvalid; endproperty
    a_wresp: assert property (p_wresp) else $error("write response late");
    property p_rresp; s_rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rresp: assert property (p_rresp) else $error("read response late");
endmodule

bind fll_clock_mode_control fll_clock_mode_control_assertions fll_clock_mode_control_assertions_i (.*);

// [tb_fll_clock_mode_control.sv]
// self-checking bench for the clock mode controller
`timescale 1ns/1ns
`include "fll_clock_mode_control_consts.svh"

module tb_fll_clock_mode_control;
    localparam logic [7:0] C1 = `OFF_CTRL1;
    localparam logic [7:0] C2 = `OFF_CTRL2;
    localparam logic [7:0] TR = `OFF_REF_TRIM;
    localparam logic [7:0] ST = `OFF_CLOCK_STATUS_FINE_TRIM;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_run = 1'b1;
    logic int_ref_clk = 1'b0, ext_ref_clk = 1'b0, fll_clk = 1'b0;
    logic ext_osc_ready = 1'b0, stop_mode = 1'b0, debug_mode_active = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic core_clock_out, debug_link_clock, int_ref_clock_out, ext_ref_clock_out;
    logic fll_enable, fll_ref_clk, fll_relock_start, ext_osc_enable;
    logic ext_osc_high_range, ext_osc_high_gain;
    logic [9:0] fll_multiplier;
    logic [8:0] int_ref_period_code;
    logic [7:0] cnt = 8'h00;
    logic [33:0] rq[$];
    int fail_count = 0;
    int total_checks = 0;

    fll_clock_mode_control fll_clock_mode_control_i (.*);

    initial forever #5 clk = ~clk;

    // slow sources: internal 16, fll 8, external 32 cycles
    always @(posedge clk) begin
        cnt <= cnt + 8'h01;
        int_ref_clk <= cnt[3];
        fll_clk <= cnt[2];
        if (ext_run) ext_ref_clk <= cnt[4];
    end

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, rq.pop_front());
    end

    task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d,
                       input logic [1:0] r);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        rq.push_back(w ? {r, 32'h0} : {r, 24'h0, d});
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
        end
        while (!done && n < 100) begin
            @(posedge clk);
            n++;
            if (w && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!w && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) begin
                done = 1'b1;
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end else begin
                s_axi_bready <= s_axi_bvalid;
                s_axi_rready <= s_axi_rvalid;
            end
        end
        if (!done) fail_count++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
        bus(1'b0, a, d, r);
    endtask

    // rising-edge spacing of core clock (s=0) or fll reference (s=1)
    task automatic period(input bit s, input int e);
        int n, k, p;
        logic prev, cur;
        n = 0;
        k = 0;
        p = 0;
        prev = 1'b1;
        while (k < 3 && n < 8000) begin
            @(posedge clk);
            n++;
            cur = s ? fll_ref_clk : core_clock_out;
            if (cur && !prev) k++;
            if (cur && !prev && k == 2) p = n;
            if (cur && !prev && k == 3) p = n - p;
            prev = cur;
        end
        check(34'(p >= e - 1 && p <= e + 1), 34'h1);
    endtask

    task automatic watch(output int hi_i, output int hi_e);
        hi_i = 0;
        hi_e = 0;
        repeat (100) begin
            @(posedge clk);
            hi_i += int_ref_clock_out;
            hi_e += ext_ref_clock_out;
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        fail_count++;
        tally_and_finish;
    end

    initial begin
        int p, hi_i, hi_e;
        logic [7:0] t;
        logic f;
        void'($urandom(32'h68954D80));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        check(34'(int_ref_period_code), 34'({`REF_TRIM_RESET, `FINE_TRIM_RESET}));
        check(34'(fll_enable), 34'h1);
        rd(C1, `CTRL1_RESET);
        rd(C2, `CTRL2_RESET);
        rd(TR, `REF_TRIM_RESET);
        rd(ST, 8'h00);
        repeat (4) begin
            t = 8'($urandom);
            f = 1'($urandom);
            wr(TR, t);
            wr(ST, {7'h7F, f});
            check(34'(int_ref_period_code), 34'({t, f}));
            rd(ST, {7'h00, f});
        end
        wr(ST, 8'h00);
        wr(8'h10, 8'hFF, 2'b10);
        rd(8'h10, 8'h00, 2'b10);
        wr(C2, 8'h46);
        check(34'(ext_osc_enable), 34'h1);
        rd(ST, 8'h00);
        ext_osc_ready <= 1'b1;
        repeat (4) @(posedge clk);
        rd(ST, 8'h02);
        ext_osc_ready <= 1'b0;
        repeat (4) @(posedge clk);
        rd(ST, 8'h02);
        wr(C2, 8'h42);
        rd(ST, 8'h00);
        ext_osc_ready <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            wr(C2, {2'(b), 6'h00});
            period(1'b0, 8 << b);
        end
        for (int r = 0; r < 8; r++) begin
            wr(C1, {2'b00, 3'(r), 3'b100});
            period(1'b1, 16 << r);
        end
        wr(C1, 8'h00);
        p = 0;
        while (!fll_relock_start && p < 400) begin
            @(posedge clk);
            p++;
        end
        check(34'(p > (`RELOCK_EDGES - 1) * 32 - 4 && p < `RELOCK_EDGES * 32 + 8), 34'h1);
        check(34'(fll_enable), 34'h1);
        wr(C1, 8'h44);
        rd(ST, 8'h00);
        repeat (120) @(posedge clk);
        rd(ST, 8'h04);
        ext_run <= 1'b0;
        wr(C1, 8'h80);
        repeat (200) @(posedge clk);
        rd(ST, 8'h04);
        ext_run <= 1'b1;
        repeat (200) @(posedge clk);
        rd(ST, 8'h08);
        wr(C1, 8'hC4);
        repeat (120) @(posedge clk);
        rd(ST, 8'h00);
        wr(C1, 8'h44);
        wr(C2, 8'h48);
        repeat (3) @(posedge clk);
        check(34'(fll_enable), 34'h0);
        debug_mode_active <= 1'b1;
        repeat (3) @(posedge clk);
        check(34'(fll_enable), 34'h1);
        debug_mode_active <= 1'b0;
        wr(C1, 8'h80);
        repeat (3) @(posedge clk);
        check(34'(fll_enable), 34'h0);
        wr(C2, 8'h40);
        repeat (3) @(posedge clk);
        check(34'(fll_enable), 34'h1);
        ce <= 1'b0;
        @(posedge clk);
        f = core_clock_out;
        repeat (40) @(posedge clk);
        check(34'(core_clock_out), 34'(f));
        ce <= 1'b1;
        wr(C1, 8'h07);
        wr(C2, 8'h43);
        stop_mode <= 1'b1;
        watch(hi_i, hi_e);
        check(34'(hi_i > 0 && hi_e > 0), 34'h1);
        wr(C1, 8'h06);
        wr(C2, 8'h42);
        watch(hi_i, hi_e);
        check(34'(hi_i + hi_e), 34'h0);
        stop_mode <= 1'b0;
        tally_and_finish;
    end
endmodule
